//--- pkg/content_protect_link_check_defines.svh
// Offsets, field positions, reset values and counts for the link check ends
`ifndef CONTENT_PROTECT_LINK_CHECK_DEFINES_SVH
`define CONTENT_PROTECT_LINK_CHECK_DEFINES_SVH

`define CHECK_W          16
`define DATA_W           8
`define FRAME_CNT_W      4
`define FRAME_CNT_LAST   4'hf
`define FRAME_CNT_ONE    4'h1
`define KEY_SEED         16'hace1
`define KEY_TAPS         16'hb400
`define MISMATCH_LIMIT   2'h2
`define MISMATCH_ONE     2'h1
`define LOW_VALUE_BYTE   8'h00

`define ADDR_W           8
`define OFF_CTRL         8'h00
`define OFF_STATUS       8'h04
`define OFF_IRQ_STAT     8'h08
`define OFF_IRQ_MASK     8'h0c
`define OFF_CHECK        8'h10
`define OFF_RX_CHECK     8'h14

`define CTRL_W           8
`define CTRL_RESET       8'h00
`define CTRL_CHECK_ON    0
`define CTRL_ENC_ON      1
`define CTRL_RESTART     2
`define CTRL_PIN1_ROLE   3
`define CTRL_PIN0_ROLE   4
`define CTRL_REPEATER    5
`define CTRL_VIDEO_OVR   6
`define CTRL_AUDIO_OVR   7

`define IRQ_W            6
`define IRQ_RESET        6'h00
`define IRQ_PASS         0
`define IRQ_FAIL         1
`define IRQ_AUTH_BEGUN   2
`define IRQ_ENC_CHANGE   3
`define IRQ_NEW_DEVICE   4
`define IRQ_MISMATCH     5

`endif

//--- pkg/content_protect_link_check_pkg.sv
// Types shared by the serializer end and the controller end
package content_protect_link_check_pkg;

  typedef enum logic [1:0] {
    DEV_WAIT_AUTH = 2'b00,
    DEV_AUTHED    = 2'b01,
    DEV_ENCRYPT   = 2'b10
  } dev_state_t;

  typedef enum logic [2:0] {
    CTL_IDLE       = 3'b000,
    CTL_COMPARE    = 3'b001,
    CTL_FAIL       = 3'b010,
    CTL_PROT_RESET = 3'b011,
    CTL_AUTH_START = 3'b100
  } ctl_state_t;

  typedef struct packed {
    dev_state_t  state;
    logic [15:0] keyLfsr;
    logic [15:0] signature;
    logic [3:0]  frameCount;
    logic [15:0] checkValue;
    logic        checkUpdate;
    logic [7:0]  linkData;
    logic        linkValid;
  } dev_regs_t;

  typedef struct packed {
    ctl_state_t  state;
    logic [7:0]  ctrl;
    logic [5:0]  irqStat;
    logic [5:0]  irqMask;
    logic        irq;
    logic [1:0]  mismatchCount;
    logic        failed;
    logic [15:0] lastCheck;
    logic [15:0] lastRxCheck;
    logic        protReset;
    logic        authStart;
    logic        fromRepeater;
    logic        clearAuthBegun;
    logic        repeaterWrite;
    logic        repeaterDone;
    logic        rxPowerDown;
    logic        newDeviceSet;
    logic        prevAuthBegun;
    logic        prevPin1;
    logic        prevPin0;
    logic        wbAck;
    logic [31:0] wbDat;
  } ctl_regs_t;

endpackage

//--- pkg/link_check_if.sv
// Control channel between the controller and the serializer
`timescale 1ns/1ps
`include "content_protect_link_check_defines.svh"
interface link_check_if;
  logic                  encEnable;
  logic                  protReset;
  logic                  authStart;
  logic                  videoOverride;
  logic                  audioOverride;
  logic [`CHECK_W-1:0]   checkValue;
  logic                  checkUpdate;
  logic [1:0]            authState;

  modport device (
    input  encEnable,
    input  protReset,
    input  authStart,
    input  videoOverride,
    input  audioOverride,
    output checkValue,
    output checkUpdate,
    output authState
  );

  modport controller (
    output encEnable,
    output protReset,
    output authStart,
    output videoOverride,
    output audioOverride,
    input  checkValue,
    input  checkUpdate,
    input  authState
  );
endinterface

//--- hdl/link_check_serializer.sv
// Serializer end: stream encryption and enhanced check value generation
`timescale 1ns/1ps
`include "content_protect_link_check_defines.svh"
module link_check_serializer (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               ce,
  input  wire logic               frameSync,
  input  wire logic [`DATA_W-1:0] avData,
  input  wire logic               avValid,
  output logic      [`DATA_W-1:0] linkData,
  output logic                    linkValid,
  link_check_if.device            ctl
);
  content_protect_link_check_pkg::dev_regs_t r;
  content_protect_link_check_pkg::dev_regs_t n;

  logic [`DATA_W-1:0] plain;
  logic               wrap;

  always_comb begin
    n = r;
    n.checkUpdate = 1'b0;
    wrap = 1'b0;
    // Overridden inputs are replaced by a fixed low-value byte
    plain = (ctl.videoOverride || ctl.audioOverride) ? `LOW_VALUE_BYTE : avData;
    case (r.state)
      content_protect_link_check_pkg::DEV_WAIT_AUTH: begin
        if (ctl.authStart) begin
          n.state = content_protect_link_check_pkg::DEV_AUTHED;
        end
      end
      content_protect_link_check_pkg::DEV_AUTHED: begin
        if (ctl.encEnable) begin
          n.state = content_protect_link_check_pkg::DEV_ENCRYPT;
          n.frameCount = '0;
          n.keyLfsr = `KEY_SEED;
          n.signature = '0;
        end
      end
      content_protect_link_check_pkg::DEV_ENCRYPT: begin
        if (!ctl.encEnable) begin
          n.state = content_protect_link_check_pkg::DEV_AUTHED;
        end else if (frameSync) begin
          n.frameCount = r.frameCount + `FRAME_CNT_ONE;
          wrap = (r.frameCount == `FRAME_CNT_LAST);
        end
        if (wrap) begin
          n.checkValue = r.signature;
          n.checkUpdate = 1'b1;
        end
      end
      default: n.state = content_protect_link_check_pkg::DEV_WAIT_AUTH;
    endcase
    // Restart drops any session, back to waiting for authentication
    if (ctl.protReset) begin
      n.state = content_protect_link_check_pkg::DEV_WAIT_AUTH;
    end
    // Stream keeps flowing in every state; only the keystream use changes
    n.linkValid = avValid;
    if (avValid) begin
      if (r.state == content_protect_link_check_pkg::DEV_ENCRYPT && ctl.encEnable) begin
        n.linkData = plain ^ r.keyLfsr[`DATA_W-1:0];
        n.keyLfsr = {r.keyLfsr[14:0], ^(r.keyLfsr & `KEY_TAPS)};
        n.signature = {r.signature[14:0], r.signature[15]} ^ {r.keyLfsr[15:8], n.linkData};
      end else begin
        n.linkData = plain;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r.state <= content_protect_link_check_pkg::DEV_WAIT_AUTH;
      r.keyLfsr <= `KEY_SEED;
      r.signature <= '0;
      r.frameCount <= '0;
      r.checkValue <= '0;
      r.checkUpdate <= 1'b0;
      r.linkData <= '0;
      r.linkValid <= 1'b0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign linkData = r.linkData;
  assign linkValid = r.linkValid;
  assign ctl.checkValue = r.checkValue;
  assign ctl.checkUpdate = r.checkUpdate;
  assign ctl.authState = r.state;
endmodule

//--- hdl/link_check_controller.sv
// Controller end: check comparison, failure handling and repeater notification
//
// Operation
// - Serializer refreshes check value every sixteen frames
// - Serializer keeps encrypting the stream meanwhile
// - Controller reads both check values each period
// - Equal values pass, wait next period
// - Fail only after three consecutive mismatches; a pass clears the count
// - On failure mask stream with override bits
// - On failure clear encryption enable both ends
// - Cleared enable sends content in the clear
// - Restart: protection reset, then authentication start
// - New device sets flag and raises interrupt
// - Repeater authenticates only on upstream request
// - Receiver sets begun flag, drives pin one
// - Rising begun flag starts downstream, then clear
// - Pin zero follows receiver encryption enable
// - Set repeater bit, retry until acknowledged
// - Hold receiver powered down until repeater ready
// - All ends idle waiting for authentication
`timescale 1ns/1ps
`include "content_protect_link_check_defines.svh"
module link_check_controller (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                ce,
  input  wire logic                wbCyc,
  input  wire logic                wbStb,
  input  wire logic                wbWe,
  input  wire logic [3:0]          wbSel,
  input  wire logic [`ADDR_W-1:0]  wbAdr,
  input  wire logic [31:0]         wbDatI,
  output logic      [31:0]         wbDatO,
  output logic                     wbAck,
  output logic                     irq,
  input  wire logic [`CHECK_W-1:0] rxCheckValue,
  output logic                     rxEncEnable,
  input  wire logic                authBegunFlag,
  input  wire logic                generalPin1,
  input  wire logic                generalPin0,
  output logic                     clearAuthBegun,
  output logic                     pin1RoleSelect,
  output logic                     pin0RoleSelect,
  output logic                     repeaterWrite,
  input  wire logic                repeaterAck,
  output logic                     rxPowerDown,
  input  wire logic                newDeviceSeen,
  output logic                     newDeviceSet,
  link_check_if.controller         ser
);
  content_protect_link_check_pkg::ctl_regs_t r;
  content_protect_link_check_pkg::ctl_regs_t n;

  logic               access;
  logic               wrCtrl;
  logic [`IRQ_W-1:0]  irqSet;
  logic [`IRQ_W-1:0]  irqClr;
  logic               authRise;

  always_comb begin
    n = r;
    irqSet = '0;
    irqClr = '0;
    n.protReset = 1'b0;
    n.authStart = 1'b0;
    n.clearAuthBegun = 1'b0;
    n.newDeviceSet = 1'b0;
    n.prevAuthBegun = authBegunFlag;
    n.prevPin1 = generalPin1;
    n.prevPin0 = generalPin0;

    // Bus slave: one wait state, ack for one cycle, unmapped reads as zero
    access = wbCyc && wbStb && !r.wbAck;
    // Writes land on the edge that sees ack, as a classic master expects
    wrCtrl = wbCyc && wbStb && r.wbAck && wbWe && wbSel[0] && (wbAdr == `OFF_CTRL);
    n.wbAck = access;
    n.wbDat = '0;
    if (access && !wbWe) begin
      case (wbAdr)
        `OFF_CTRL:     n.wbDat = {24'h000000, r.ctrl};
        `OFF_STATUS:   n.wbDat = {28'h0000000, r.mismatchCount, r.failed, r.repeaterDone};
        `OFF_IRQ_STAT: n.wbDat = {26'h0000000, r.irqStat};
        `OFF_IRQ_MASK: n.wbDat = {26'h0000000, r.irqMask};
        `OFF_CHECK:    n.wbDat = {16'h0000, r.lastCheck};
        `OFF_RX_CHECK: n.wbDat = {16'h0000, r.lastRxCheck};
        default:       n.wbDat = '0;
      endcase
    end
    if (wrCtrl) begin
      n.ctrl = wbDatI[`CTRL_W-1:0];
      n.ctrl[`CTRL_RESTART] = 1'b0;
    end
    if (wbCyc && wbStb && r.wbAck && wbWe && wbSel[0] && wbAdr == `OFF_IRQ_STAT) begin
      irqClr = wbDatI[`IRQ_W-1:0];
    end
    if (wbCyc && wbStb && r.wbAck && wbWe && wbSel[0] && wbAdr == `OFF_IRQ_MASK) begin
      n.irqMask = wbDatI[`IRQ_W-1:0];
    end

    // Upstream request only; reset and new devices never start it
    authRise = (authBegunFlag && !r.prevAuthBegun) ||
               (r.ctrl[`CTRL_PIN1_ROLE] && generalPin1 && !r.prevPin1);

    case (r.state)
      content_protect_link_check_pkg::CTL_IDLE: begin
        if (ser.checkUpdate && r.ctrl[`CTRL_CHECK_ON] && r.ctrl[`CTRL_ENC_ON]) begin
          n.lastCheck = ser.checkValue;
          n.lastRxCheck = rxCheckValue;
          n.state = content_protect_link_check_pkg::CTL_COMPARE;
        end else if (wrCtrl && wbDatI[`CTRL_RESTART]) begin
          n.state = content_protect_link_check_pkg::CTL_PROT_RESET;
        end else if (authRise && r.ctrl[`CTRL_REPEATER] && r.repeaterDone) begin
          n.fromRepeater = 1'b1;
          n.state = content_protect_link_check_pkg::CTL_PROT_RESET;
        end
      end
      content_protect_link_check_pkg::CTL_COMPARE: begin
        if (r.lastCheck == r.lastRxCheck) begin
          n.mismatchCount = '0;
          irqSet[`IRQ_PASS] = 1'b1;
          n.state = content_protect_link_check_pkg::CTL_IDLE;
        end else if (r.mismatchCount == `MISMATCH_LIMIT) begin
          n.mismatchCount = '0;
          n.failed = 1'b1;
          irqSet[`IRQ_FAIL] = 1'b1;
          n.state = content_protect_link_check_pkg::CTL_FAIL;
        end else begin
          // Retry waits for the next period rather than rereading a stale value
          n.mismatchCount = r.mismatchCount + `MISMATCH_ONE;
          irqSet[`IRQ_MISMATCH] = 1'b1;
          n.state = content_protect_link_check_pkg::CTL_IDLE;
        end
      end
      content_protect_link_check_pkg::CTL_FAIL: begin
        n.ctrl[`CTRL_VIDEO_OVR] = 1'b1;
        n.ctrl[`CTRL_AUDIO_OVR] = 1'b1;
        n.ctrl[`CTRL_ENC_ON] = 1'b0;
        n.state = content_protect_link_check_pkg::CTL_PROT_RESET;
      end
      content_protect_link_check_pkg::CTL_PROT_RESET: begin
        n.protReset = 1'b1;
        n.state = content_protect_link_check_pkg::CTL_AUTH_START;
      end
      content_protect_link_check_pkg::CTL_AUTH_START: begin
        n.authStart = 1'b1;
        n.clearAuthBegun = r.fromRepeater;
        n.fromRepeater = 1'b0;
        n.state = content_protect_link_check_pkg::CTL_IDLE;
      end
      default: n.state = content_protect_link_check_pkg::CTL_IDLE;
    endcase

    // Repeater bit held asserted until the receiver acknowledges
    n.repeaterWrite = r.ctrl[`CTRL_REPEATER] && !r.repeaterDone && !repeaterAck;
    if (r.repeaterWrite && repeaterAck) begin
      n.repeaterDone = 1'b1;
    end
    if (!r.ctrl[`CTRL_REPEATER]) begin
      n.repeaterDone = 1'b0;
    end
    n.rxPowerDown = n.ctrl[`CTRL_REPEATER] && !n.repeaterDone;

    if (authRise) begin
      irqSet[`IRQ_AUTH_BEGUN] = 1'b1;
    end
    if (r.ctrl[`CTRL_PIN0_ROLE] && (generalPin0 != r.prevPin0)) begin
      irqSet[`IRQ_ENC_CHANGE] = 1'b1;
    end
    if (newDeviceSeen) begin
      n.newDeviceSet = 1'b1;
      irqSet[`IRQ_NEW_DEVICE] = 1'b1;
    end
    // Failure stays visible through the automatic restart until software restarts
    if (wrCtrl && wbDatI[`CTRL_RESTART]) begin
      n.failed = 1'b0;
    end

    // Set beats clear so an event in the clearing cycle is kept
    n.irqStat = (r.irqStat & ~irqClr) | irqSet;
    n.irq = |(n.irqStat & n.irqMask);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r.state <= content_protect_link_check_pkg::CTL_IDLE;
      r.ctrl <= `CTRL_RESET;
      r.irqStat <= `IRQ_RESET;
      r.irqMask <= `IRQ_RESET;
      r.irq <= 1'b0;
      r.mismatchCount <= '0;
      r.failed <= 1'b0;
      r.lastCheck <= '0;
      r.lastRxCheck <= '0;
      r.protReset <= 1'b0;
      r.authStart <= 1'b0;
      r.fromRepeater <= 1'b0;
      r.clearAuthBegun <= 1'b0;
      r.repeaterWrite <= 1'b0;
      r.repeaterDone <= 1'b0;
      r.rxPowerDown <= 1'b0;
      r.newDeviceSet <= 1'b0;
      r.prevAuthBegun <= 1'b0;
      r.prevPin1 <= 1'b0;
      r.prevPin0 <= 1'b0;
      r.wbAck <= 1'b0;
      r.wbDat <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign wbDatO = r.wbDat;
  assign wbAck = r.wbAck;
  assign irq = r.irq;
  assign rxEncEnable = r.ctrl[`CTRL_ENC_ON];
  assign pin1RoleSelect = r.ctrl[`CTRL_PIN1_ROLE];
  assign pin0RoleSelect = r.ctrl[`CTRL_PIN0_ROLE];
  assign clearAuthBegun = r.clearAuthBegun;
  assign repeaterWrite = r.repeaterWrite;
  assign rxPowerDown = r.rxPowerDown;
  assign newDeviceSet = r.newDeviceSet;
  assign ser.encEnable = r.ctrl[`CTRL_ENC_ON];
  assign ser.videoOverride = r.ctrl[`CTRL_VIDEO_OVR];
  assign ser.audioOverride = r.ctrl[`CTRL_AUDIO_OVR];
  assign ser.protReset = r.protReset;
  assign ser.authStart = r.authStart;
endmodule

//--- tb/content_protect_link_check_properties.sv
// Interface checks between controller and serializer
`timescale 1ns/1ps
module link_check_properties (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        encEnable,
  input wire logic        protReset,
  input wire logic        authStart,
  input wire logic        videoOverride,
  input wire logic        audioOverride,
  input wire logic [15:0] checkValue,
  input wire logic        checkUpdate,
  input wire logic [1:0]  authState
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_idle_after_reset: assert property ($fell(reset) |-> authState == 2'h0 && !checkUpdate)
    else $error("not idle after reset");
  a_update_pulse: assert property (checkUpdate |=> !checkUpdate)
    else $error("check update longer than one cycle");
  a_update_encrypting: assert property (checkUpdate |-> authState == 2'h2)
    else $error("check update while not encrypting");
  a_reset_then_start: assert property (protReset |-> ##[1:4] authStart)
    else $error("no start after protection reset");
  a_start_apart: assert property (authStart |-> !protReset)
    else $error("start together with reset");
  a_reset_pulse: assert property (protReset |=> !protReset)
    else $error("protection reset not a pulse");
  a_stop_encrypt: assert property ($fell(encEnable) |-> ##[0:3] authState != 2'h2)
    else $error("still encrypting after enable cleared");
  a_fail_masks: assert property ($rose(videoOverride) |-> ##[0:2] (!encEnable && audioOverride))
    else $error("override without enable cleared");
endmodule

//--- tb/content_protect_link_check_test.sv
// Self-checking bench for both link check ends
`timescale 1ns/1ps
`include "content_protect_link_check_defines.svh"
module content_protect_link_check_test;
  logic        clk = 1'b0, reset = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [7:0]  wbAdr = 8'h00, avData = 8'h00, pd = 8'h00, linkData;
  logic [31:0] wbDatI = 32'h0, wbDatO, q;
  logic        wbAck, irq, rxEnc, clrAuth, p1Role, p0Role, repWr, rxPd, newSet, linkValid;
  logic        repAck = 1'b0, newSeen = 1'b0, frameSync = 1'b0, avValid = 1'b0, pv = 1'b0;
  logic        authFlag = 1'b0, pin0 = 1'b0, pin1 = 1'b0;
  logic [15:0] flip = 16'h0, seen = 16'h0, rxCheck;
  logic [3:0]  ev;
  int          seed = 32'h89d3, mismatches = 0, checks = 0, updates = 0, starts = 0, mode = 0, mm;

  link_check_if lc ();
  always #12.5 clk = ~clk;
  // Receiver mirrors the serializer unless a fault is injected
  assign rxCheck = lc.checkValue ^ flip;
  assign ev = {lc.authState == 2'h2, repWr, clrAuth, newSet};

  link_check_controller i_link_check_controller (.clk(clk), .reset(reset), .ce(1'b1), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbSel(4'h1), .wbAdr(wbAdr), .wbDatI(wbDatI), .wbDatO(wbDatO),
    .wbAck(wbAck), .irq(irq), .rxCheckValue(rxCheck), .rxEncEnable(rxEnc), .authBegunFlag(authFlag),
    .generalPin1(pin1), .generalPin0(pin0), .clearAuthBegun(clrAuth), .pin1RoleSelect(p1Role),
    .pin0RoleSelect(p0Role), .repeaterWrite(repWr), .repeaterAck(repAck), .rxPowerDown(rxPd),
    .newDeviceSeen(newSeen), .newDeviceSet(newSet), .ser(lc.controller));
  link_check_serializer i_link_check_serializer (.clk(clk), .reset(reset), .ce(1'b1),
    .frameSync(frameSync), .avData(avData), .avValid(avValid), .linkData(linkData),
    .linkValid(linkValid), .ctl(lc.device));
  link_check_properties i_link_check_properties (.clk(clk), .reset(reset), .encEnable(lc.encEnable),
    .protReset(lc.protReset), .authStart(lc.authStart), .videoOverride(lc.videoOverride),
    .audioOverride(lc.audioOverride), .checkValue(lc.checkValue), .checkUpdate(lc.checkUpdate),
    .authState(lc.authState));

  task complete_run;
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task tmo;
    mismatches++;
    complete_run();
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatI <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wbAck === 1'b1) break;
    end
    if (i == 20) tmo();
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
    wb(1'b0, a, 32'h0);
    chk(n, e, q & m);
  endtask

  task waitBit(input int k);
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      if (ev[k] === 1'b1) break;
    end
    if (i == 200) tmo();
  endtask

  task frames(input int n);
    repeat (n) begin
      frameSync <= 1'b1;
      @(posedge clk);
      frameSync <= 1'b0;
      repeat (7) @(posedge clk);
    end
  endtask

  // One sixteen-frame period; a bad round corrupts the receiver value
  task round(input logic bad);
    int u;
    u = updates;
    flip <= bad ? (16'($random(seed)) | 16'h0001) : 16'h0000;
    frames(15);
    chk("early update", u, updates);
    frames(1);
    repeat (4) @(posedge clk);
    chk("update count", u + 1, updates);
  endtask

  always @(posedge clk) begin
    if (lc.checkUpdate === 1'b1) begin
      updates++;
      seen <= lc.checkValue;
    end
    if (lc.authStart === 1'b1) starts++;
  end

  // Stream model: one cycle delay, clear or masked as the mode says
  always @(posedge clk) begin
    pd <= avData;
    pv <= avValid;
    avData <= 8'($random(seed));
    avValid <= 1'($random(seed));
    if (mode != 0) begin
      chk("linkValid", pv, linkValid);
      if (pv && mode == 1) chk("clear data", pd, linkData);
      if (pv && mode == 2) chk("masked data", `LOW_VALUE_BYTE, linkData);
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    mode <= 1;
    repeat (20) @(posedge clk);
    chk("idle state", 2'h0, lc.authState);
    rd(`OFF_CTRL, 32'hffffffff, 32'h0, "ctrl reset");
    rd(8'h20, 32'hffffffff, 32'h0, "unmapped");
    wb(1'b1, `OFF_IRQ_MASK, 32'h3f);
    mode <= 3;
    wb(1'b1, `OFF_CTRL, 32'h07);
    waitBit(3);
    chk("rx enable", 1'b1, rxEnc);
    round(1'b0);
    rd(`OFF_IRQ_STAT, 32'h23, 32'h01, "pass flag");
    chk("irq", 1'b1, irq);
    wb(1'b1, `OFF_IRQ_STAT, 32'h3f);
    rd(`OFF_IRQ_STAT, 32'h3f, 32'h0, "cleared flags");
    chk("irq cleared", 1'b0, irq);
    wb(1'b1, `OFF_IRQ_MASK, 32'h01);
    for (mm = 1; mm < 3; mm++) begin
      round(1'b1);
      rd(`OFF_STATUS, 32'h0e, 32'(mm) << 2, "mismatch count");
      rd(`OFF_CHECK, 32'hffff, {16'h0000, seen}, "serializer check");
      rd(`OFF_RX_CHECK, 32'hffff, {16'h0000, seen ^ flip}, "receiver check");
    end
    rd(`OFF_IRQ_STAT, 32'h22, 32'h20, "mismatch flag");
    chk("masked irq", 1'b0, irq);
    round(1'b1);
    rd(`OFF_STATUS, 32'h02, 32'h02, "failed");
    rd(`OFF_CTRL, 32'hc2, 32'hc0, "overrides");
    chk("rx enable off", 1'b0, rxEnc);
    wb(1'b1, `OFF_IRQ_MASK, 32'h3f);
    repeat (2) @(posedge clk);
    chk("fail irq", 1'b1, irq);
    mode <= 2;
    repeat (20) @(posedge clk);
    chk("not encrypting", 1'b1, lc.authState != 2'h2);
    mode <= 0;
    wb(1'b1, `OFF_CTRL, 32'h38);
    @(posedge clk);
    mode <= 1;
    waitBit(2);
    mm = starts;
    authFlag <= 1'b1;
    repeat (4) @(posedge clk);
    chk("early start", mm, starts);
    authFlag <= 1'b0;
    repAck <= 1'b1;
    @(posedge clk);
    repAck <= 1'b0;
    repeat (3) @(posedge clk);
    rd(`OFF_STATUS, 32'h01, 32'h01, "repeater done");
    chk("rx power down", 1'b0, rxPd);
    chk("pin roles", 2'h3, {p1Role, p0Role});
    authFlag <= 1'b1;
    waitBit(1);
    rd(`OFF_IRQ_STAT, 32'h04, 32'h04, "begun flag");
    wb(1'b1, `OFF_IRQ_STAT, 32'h04);
    pin1 <= 1'b1;
    waitBit(1);
    rd(`OFF_IRQ_STAT, 32'h04, 32'h04, "pin1 begun");
    newSeen <= 1'b1;
    @(posedge clk);
    newSeen <= 1'b0;
    waitBit(0);
    rd(`OFF_IRQ_STAT, 32'h10, 32'h10, "new device");
    pin0 <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`OFF_IRQ_STAT, 32'h08, 32'h08, "pin0 change");
    complete_run();
  end
endmodule
